// >>> rtmch_core.v
// Tag command handler: frame decode, state, memory, reply and stream serialiser
//
// Added by the designer: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`include "rtmch_regs.vh"
module rtmch_core #(
  parameter [31:0] P_WRESP_CYC = `RTMCH_T_WRESP_CYC,
  parameter [31:0] P_PROG_CYC = `RTMCH_T_PROG_CYC,
  parameter [31:0] P_RESET_CYC = `RTMCH_T_RESET_CYC,
  parameter [31:0] P_TTF_CYC = `RTMCH_STREAM_START_DELAY_CYC
) (
  input wire i_ref_clk,
  input wire i_srst,
  input wire [7:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0] i_avs_byteenable,
  output wire [31:0] o_avs_readdata,
  output wire o_avs_waitrequest,
  input wire i_field_on,
  input wire i_rx_valid,
  input wire i_rx_bit,
  input wire i_rx_eof,
  input wire i_id_req,
  input wire [1:0] i_id_mode,
  input wire i_select_ok,
  input wire i_auth_ok,
  output wire o_tx_valid,
  output wire o_tx_bit,
  input wire i_tx_ready,
  output wire o_tx_stream,
  output wire o_tx_code_sel,
  output wire [1:0] o_tx_rate,
  output wire [6:0] o_tag_state
);
  localparam [6:0] T_READY = 7'h01;
  localparam [6:0] T_INIT = 7'h02;
  localparam [6:0] T_AUTH = 7'h04;
  localparam [6:0] T_SEL = 7'h08;
  localparam [6:0] T_QUIET = 7'h10;
  localparam [6:0] T_TTFW = 7'h20;
  localparam [6:0] STREAM_START_DELAY = 7'h40;
  localparam [4:0] P_IDLE = 5'h01;
  localparam [4:0] P_WAIT = 5'h02;
  localparam [4:0] P_TX = 5'h04;
  localparam [4:0] P_WDATA = 5'h08;
  localparam [4:0] P_PROG = 5'h10;
  localparam [1:0] POST_IDLE = 2'h0;
  localparam [1:0] POST_QUIET = 2'h1;
  localparam [1:0] POST_WDATA = 2'h2;
  localparam [1:0] PH_SOF = 2'h0;
  localparam [1:0] PH_PAY = 2'h1;
  localparam [1:0] PH_CRC = 2'h2;

  function [7:0] crc_step(input [7:0] c, input b);
    reg fb;
    begin
      fb = c[7] ^ b;
      crc_step = {c[6:0], 1'b0} ^ (fb ? `RTMCH_CRC_POLY : 8'h00);
    end
  endfunction

  // First byte on the air is the low byte
  function [31:0] byte_swap(input [31:0] w);
    begin
      byte_swap = {w[7:0], w[15:8], w[23:16], w[31:24]};
    end
  endfunction

  function [31:0] lane_merge(input [3:0] be, input [31:0] nw,
                             input [31:0] old);
    integer k;
    begin
      lane_merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (be[k]) begin
          lane_merge[k*8 +: 8] = nw[k*8 +: 8];
        end
      end
    end
  endfunction

  function tx_bit_f(input [1:0] ph, input [7:0] cnt, input [4:0] pos,
                    input ack, input [31:0] w, input [7:0] crc);
    begin
      if (ph == PH_SOF) begin
        tx_bit_f = 1'b1;
      end else if (ph == PH_PAY) begin
        // Low byte first, MSB first in byte
        tx_bit_f = ack ? (cnt == 8'h00) : w[{pos[4:3], ~pos[2:0]}];
      end else begin
        tx_bit_f = crc[cnt[2:0]];
      end
    end
  endfunction

  reg [31:0] mem_reg [0:63];
  reg [6:0] tag_reg;
  reg [4:0] proc_reg;
  reg [1:0] post_reg;
  reg [1:0] mode_reg;
  reg rtf_reg;
  reg [31:0] tmr_reg;
  reg [31:0] off_reg;
  reg [31:0] ttf_reg;
  reg [44:0] rx_sh_reg;
  reg [5:0] rx_len_reg;
  reg [7:0] rx_crc_reg;
  reg rep_ack_reg;
  reg [5:0] rep_page_reg;
  reg [2:0] rep_np_reg;
  reg [5:0] wpage_reg;
  reg [2:0] wleft_reg;
  reg [31:0] wdata_reg;
  reg [31:0] serial_reg;
  reg [5:0] maddr_reg;
  reg av_ack_reg;
  reg [31:0] rdata_reg;
  reg tx_on_reg;
  reg [1:0] tx_ph_reg;
  reg [7:0] tx_cnt_reg;
  reg [4:0] tx_pos_reg;
  reg [5:0] tx_page_reg;
  reg tx_ack_reg;
  reg [7:0] tx_crc_reg;
  reg tx_wcrc_reg;
  reg tx_strm_reg;
  reg [2:0] tx_np_reg;
  reg tx_bit_reg;
  reg code_reg;
  reg [1:0] rate_reg;

  reg tx_on_next;
  reg [1:0] tx_ph_next;
  reg [7:0] tx_cnt_next;
  reg [4:0] tx_pos_next;
  reg [5:0] tx_page_next;
  reg tx_ack_next;
  reg [7:0] tx_crc_next;
  reg tx_wcrc_next;
  reg tx_strm_next;
  reg [2:0] tx_np_next;
  reg tx_done;
  reg [31:0] rd_mux;

  wire [31:0] cfg_w = mem_reg[`RTMCH_CFG_PAGE];
  wire [31:0] mem_rd = mem_reg[maddr_reg];
  wire ttf_en = cfg_w[`RTMCH_CFG_TTF_EN];
  wire auth_en = cfg_w[`RTMCH_CFG_AUTH];
  wire [1:0] len_sel = {cfg_w[`RTMCH_CFG_LEN_HI], cfg_w[`RTMCH_CFG_LEN_LO]};
  // 11 repeats page 4, 01 alternates 4 and 5
  wire [2:0] str_np = (len_sel == 2'h3) ? 3'h1 :
                      (len_sel == 2'h1) ? 3'h2 : 3'h4;
  // Field must stay off the full reset time
  wire field_reset = ~i_field_on & (off_reg == P_RESET_CYC - 32'h1);
  wire quiet = (tag_reg == T_QUIET);
  // No reception at all while silenced
  wire rx_en = i_field_on & ~quiet &
               ((proc_reg == P_IDLE) | (proc_reg == P_WDATA));
  // Residue zero only for an intact frame
  wire eof_ok = i_rx_eof & rx_en & (rx_crc_reg == 8'h00);
  wire [3:0] cmd = rx_sh_reg[19:16];
  wire [5:0] page_address = rx_sh_reg[13:8];
  wire is_cmd = (rx_len_reg == `RTMCH_LEN_CMD);
  wire is_selq = (rx_len_reg == `RTMCH_LEN_SELQ) &
                 (rx_sh_reg[44:40] == `RTMCH_SELQ_PREFIX) &
                 (byte_swap(rx_sh_reg[39:8]) == serial_reg);
  wire id_ok = i_id_req & i_field_on & ~quiet;
  wire wait_done = (proc_reg == P_WAIT) & (tmr_reg == P_WRESP_CYC - 32'h1);
  wire prog_fire = (proc_reg == P_PROG) & (tmr_reg == P_PROG_CYC - 32'h1);
  wire tx_start = wait_done | prog_fire;
  // Window over with no request: stream
  wire stream_go = (tag_reg == T_TTFW) & (ttf_reg == P_TTF_CYC - 32'h1) &
                   i_field_on & ~i_id_req;
  wire quiet_go = (proc_reg == P_TX) & tx_done & (post_reg == POST_QUIET);
  wire av_req = i_avs_read | i_avs_write;
  // Programming owns the memory port, so the bus waits
  wire av_take = av_req & av_ack_reg & ~prog_fire;

  assign o_avs_waitrequest = av_req & ~av_take;
  assign o_avs_readdata = rdata_reg;
  assign o_tx_valid = tx_on_reg;
  assign o_tx_bit = tx_bit_reg;
  assign o_tx_stream = tx_strm_reg;
  assign o_tx_code_sel = code_reg;
  assign o_tx_rate = rate_reg;
  assign o_tag_state = tag_reg;

  always @* begin
    case (i_avs_address)
      `RTMCH_REG_STATUS: rd_mux = {16'h0000, tx_on_reg, rtf_reg, mode_reg,
                                   proc_reg, tag_reg};
      `RTMCH_REG_SERIAL: rd_mux = serial_reg;
      `RTMCH_REG_MEM_ADDR: rd_mux = {26'h0000000, maddr_reg};
      `RTMCH_REG_MEM_DATA: rd_mux = mem_rd;
      default: rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      av_ack_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      serial_reg <= `RTMCH_SERIAL_RST;
      maddr_reg <= 6'h00;
    end else begin
      av_ack_reg <= av_req & ~av_take;
      if (i_avs_read) begin
        rdata_reg <= rd_mux;
      end
      if (av_take & i_avs_write) begin
        if (i_avs_address == `RTMCH_REG_SERIAL) begin
          serial_reg <= lane_merge(i_avs_byteenable, i_avs_writedata,
                                   serial_reg);
        end
        if (i_avs_address == `RTMCH_REG_MEM_ADDR & i_avs_byteenable[0]) begin
          maddr_reg <= i_avs_writedata[5:0];
        end
      end
    end
  end

  always @(posedge i_ref_clk) begin
    // Page programmed when the time is up
    if (prog_fire) begin
      mem_reg[wpage_reg] <= wdata_reg;
    end else if (av_take & i_avs_write &
                 (i_avs_address == `RTMCH_REG_MEM_DATA)) begin
      mem_reg[maddr_reg] <= lane_merge(i_avs_byteenable, i_avs_writedata,
                                       mem_rd);
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      off_reg <= 32'h00000000;
      ttf_reg <= 32'h00000000;
    end else begin
      if (i_field_on) begin
        off_reg <= 32'h00000000;
      end else if (off_reg != P_RESET_CYC) begin
        off_reg <= off_reg + 32'h1;
      end
      ttf_reg <= (tag_reg == T_TTFW) ? ttf_reg + 32'h1 : 32'h00000000;
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_srst | field_reset) begin
      tag_reg <= T_READY;
      rtf_reg <= 1'b0;
      mode_reg <= `RTMCH_MODE_STD;
    end else begin
      // Latest identity request picks the mode, except in T_QUIET and STREAM_START_DELAY
      if (id_ok & (tag_reg != STREAM_START_DELAY)) begin
        mode_reg <= i_id_mode;
      end
      case (tag_reg)
        T_READY: begin
          if (id_ok) begin
            tag_reg <= T_INIT;
          end else if (i_field_on & ttf_en & ~rtf_reg) begin
            tag_reg <= T_TTFW;
          end
        end
        T_TTFW: begin
          // Request in window: reader-first until field reset
          if (id_ok) begin
            tag_reg <= T_INIT;
            rtf_reg <= 1'b1;
          end else if (stream_go) begin
            tag_reg <= STREAM_START_DELAY;
          end
        end
        T_INIT: begin
          if (quiet_go) begin
            tag_reg <= T_QUIET;
          end else if (i_select_ok) begin
            tag_reg <= auth_en ? T_AUTH : T_SEL;
          end
        end
        T_AUTH: begin
          if (i_auth_ok) begin
            tag_reg <= T_SEL;
          end
        end
        T_SEL: begin
          // Silenced once the acknowledge is out
          if (quiet_go) begin
            tag_reg <= T_QUIET;
          end
        end
        // Only a field reset leaves these
        T_QUIET: tag_reg <= T_QUIET;
        STREAM_START_DELAY: tag_reg <= STREAM_START_DELAY;
        default: tag_reg <= T_READY;
      endcase
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_srst | field_reset) begin
      proc_reg <= P_IDLE;
      post_reg <= POST_IDLE;
      tmr_reg <= 32'h00000000;
      rx_sh_reg <= 45'h0;
      rx_len_reg <= 6'h00;
      rx_crc_reg <= `RTMCH_CRC_PRESET;
      rep_ack_reg <= 1'b0;
      rep_page_reg <= 6'h00;
      rep_np_reg <= 3'h1;
      wpage_reg <= 6'h00;
      wleft_reg <= 3'h0;
      wdata_reg <= 32'h00000000;
    end else begin
      tmr_reg <= tmr_reg + 32'h1;
      if (i_rx_eof | ~rx_en) begin
        rx_len_reg <= 6'h00;
        rx_crc_reg <= `RTMCH_CRC_PRESET;
      end else if (i_rx_valid) begin
        rx_sh_reg <= {rx_sh_reg[43:0], i_rx_bit};
        rx_crc_reg <= crc_step(rx_crc_reg, i_rx_bit);
        if (rx_len_reg != 6'h3F) begin
          rx_len_reg <= rx_len_reg + 6'h01;
        end
      end
      case (proc_reg)
        P_IDLE: begin
          tmr_reg <= 32'h00000000;
          rep_np_reg <= 3'h1;
          // Serial matches in init: reply, then silence
          if (eof_ok & is_selq & (tag_reg == T_INIT)) begin
            rep_ack_reg <= 1'b1;
            post_reg <= POST_QUIET;
            proc_reg <= P_WAIT;
          // Commands below need the selected state
          end else if (eof_ok & is_cmd & (tag_reg == T_SEL)) begin
            rep_page_reg <= page_address;
            case (cmd)
              `RTMCH_CMD_READ_PAGE: begin
                rep_ack_reg <= 1'b0;
                post_reg <= POST_IDLE;
                proc_reg <= P_WAIT;
              end
              // Addressed page to end of block
              `RTMCH_CMD_READ_BLOCK: begin
                rep_ack_reg <= 1'b0;
                rep_np_reg <= 3'h4 - {1'b0, page_address[1:0]};
                post_reg <= POST_IDLE;
                proc_reg <= P_WAIT;
              end
              `RTMCH_CMD_WRITE_PAGE, `RTMCH_CMD_WRITE_BLOCK: begin
                rep_ack_reg <= 1'b1;
                wpage_reg <= page_address;
                // Pages left up to the block end
                wleft_reg <= (cmd == `RTMCH_CMD_WRITE_PAGE) ? 3'h1 :
                             3'h4 - {1'b0, page_address[1:0]};
                post_reg <= POST_WDATA;
                proc_reg <= P_WAIT;
              end
              `RTMCH_CMD_SILENCE: begin
                rep_ack_reg <= 1'b1;
                post_reg <= POST_QUIET;
                proc_reg <= P_WAIT;
              end
              default: proc_reg <= P_IDLE;
            endcase
          end
        end
        P_WAIT: begin
          if (wait_done) begin
            proc_reg <= P_TX;
          end
        end
        P_TX: begin
          tmr_reg <= 32'h00000000;
          if (tx_done) begin
            proc_reg <= (post_reg == POST_WDATA) ? P_WDATA : P_IDLE;
          end
        end
        P_WDATA: begin
          tmr_reg <= 32'h00000000;
          // Data word plus CRC after the acknowledge
          if (eof_ok & (rx_len_reg == `RTMCH_LEN_WDATA)) begin
            wdata_reg <= byte_swap(rx_sh_reg[39:8]);
            proc_reg <= P_PROG;
          end
        end
        P_PROG: begin
          // Each page gets its own acknowledge
          if (prog_fire) begin
            rep_ack_reg <= 1'b1;
            wpage_reg <= wpage_reg + 6'h01;
            wleft_reg <= wleft_reg - 3'h1;
            post_reg <= (wleft_reg > 3'h1) ? POST_WDATA : POST_IDLE;
            proc_reg <= P_TX;
          end
        end
        default: proc_reg <= P_IDLE;
      endcase
    end
  end

  always @* begin
    tx_on_next = tx_on_reg;
    tx_ph_next = tx_ph_reg;
    tx_cnt_next = tx_cnt_reg;
    tx_pos_next = tx_pos_reg;
    tx_page_next = tx_page_reg;
    tx_ack_next = tx_ack_reg;
    tx_crc_next = tx_crc_reg;
    tx_wcrc_next = tx_wcrc_reg;
    tx_strm_next = tx_strm_reg;
    tx_np_next = tx_np_reg;
    tx_done = 1'b0;
    if (field_reset) begin
      tx_on_next = 1'b0;
      tx_strm_next = 1'b0;
    end else if (tx_start) begin
      tx_on_next = 1'b1;
      tx_ph_next = PH_SOF;
      // One start bit in standard, six otherwise
      tx_cnt_next = (mode_reg == `RTMCH_MODE_STD) ? `RTMCH_SOF_LAST_STD :
                    `RTMCH_SOF_LAST_ADV;
      tx_pos_next = 5'h00;
      tx_page_next = rep_page_reg;
      tx_ack_next = rep_ack_reg;
      tx_np_next = rep_np_reg;
      tx_crc_next = `RTMCH_CRC_PRESET;
      // Read replies carry CRC8 in advanced modes
      tx_wcrc_next = ~rep_ack_reg & (mode_reg != `RTMCH_MODE_STD);
      tx_strm_next = 1'b0;
    end else if (stream_go) begin
      tx_on_next = 1'b1;
      tx_ph_next = PH_PAY;
      tx_cnt_next = {str_np, 5'h00} - 8'h01;
      tx_pos_next = 5'h00;
      tx_page_next = `RTMCH_STREAM_PAGE;
      tx_ack_next = 1'b0;
      tx_wcrc_next = 1'b0;
      tx_strm_next = 1'b1;
    end else if (tx_on_reg & i_tx_ready) begin
      tx_cnt_next = tx_cnt_reg - 8'h01;
      case (tx_ph_reg)
        PH_SOF: begin
          if (tx_cnt_reg == 8'h00) begin
            tx_ph_next = PH_PAY;
            // Acknowledge is the two bits 01
            tx_cnt_next = tx_ack_reg ? 8'h01 : {tx_np_reg, 5'h00} - 8'h01;
          end
        end
        PH_PAY: begin
          tx_crc_next = crc_step(tx_crc_reg, tx_bit_reg);
          tx_pos_next = tx_pos_reg + 5'h01;
          if (tx_pos_reg == 5'h1F) begin
            tx_page_next = tx_page_reg + 6'h01;
          end
          if (tx_cnt_reg == 8'h00) begin
            if (tx_wcrc_reg) begin
              tx_ph_next = PH_CRC;
              tx_cnt_next = 8'h07;
            // Stream loops back to page 4
            end else if (tx_strm_reg) begin
              tx_cnt_next = {str_np, 5'h00} - 8'h01;
              tx_page_next = `RTMCH_STREAM_PAGE;
            end else begin
              tx_on_next = 1'b0;
              tx_done = 1'b1;
            end
          end
        end
        default: begin
          if (tx_cnt_reg == 8'h00) begin
            tx_on_next = 1'b0;
            tx_done = 1'b1;
          end
        end
      endcase
    end
  end

  always @(posedge i_ref_clk) begin
    if (i_srst) begin
      tx_on_reg <= 1'b0;
      tx_ph_reg <= PH_SOF;
      tx_cnt_reg <= 8'h00;
      tx_pos_reg <= 5'h00;
      tx_page_reg <= 6'h00;
      tx_ack_reg <= 1'b0;
      tx_crc_reg <= `RTMCH_CRC_PRESET;
      tx_wcrc_reg <= 1'b0;
      tx_strm_reg <= 1'b0;
      tx_np_reg <= 3'h1;
      tx_bit_reg <= 1'b0;
      code_reg <= `RTMCH_CODE_MANCH;
      rate_reg <= `RTMCH_RATE_4K;
    end else begin
      tx_on_reg <= tx_on_next;
      tx_ph_reg <= tx_ph_next;
      tx_cnt_reg <= tx_cnt_next;
      tx_pos_reg <= tx_pos_next;
      tx_page_reg <= tx_page_next;
      tx_ack_reg <= tx_ack_next;
      tx_crc_reg <= tx_crc_next;
      tx_wcrc_reg <= tx_wcrc_next;
      tx_strm_reg <= tx_strm_next;
      tx_np_reg <= tx_np_next;
      // Bit is prefetched so the output is always a flop
      tx_bit_reg <= tx_bit_f(tx_ph_next, tx_cnt_next, tx_pos_next,
                             tx_ack_next, mem_reg[tx_page_next],
                             tx_crc_next);
      if (tx_start) begin
        code_reg <= `RTMCH_CODE_MANCH;
        rate_reg <= (mode_reg == `RTMCH_MODE_FADV) ? `RTMCH_RATE_8K :
                    `RTMCH_RATE_4K;
      end
      // Stream coding and rate from own bits
      if (stream_go) begin
        code_reg <= cfg_w[`RTMCH_CFG_CODING];
        rate_reg <= {cfg_w[`RTMCH_CFG_RATE_HI], cfg_w[`RTMCH_CFG_RATE_LO]};
      end
    end
  end
endmodule

// >>> rtmch_regs.vh
// Register offsets, field positions and timing of the tag command handler
// Notes on behaviour
// - Init tag silenced by select-and-silence frame
// - Select-and-silence reply sent in Manchester code
// - Silence held until field off reset time
// - Page reads only once selected
// - Read page returns start then page data
// - Read block returns pages to block end
// - Page data travels least significant byte first
// - Writes only accepted once selected
// - Write command answered with acknowledge 01
// - Acknowledge after programming time elapses
// - Block write carries one to four pages
// - Each block page acknowledged after programming
// - Silence command acknowledged, then tag silenced
// - Configuration byte one steers streaming mode
// - Identity request in window forces reader-first
// - No request in window starts streaming
// - Length bits pick page 4, 4/5 or 4 to 7
// - Stream coding and rate set independently
// - Start pattern and rate follow response mode
// - CRC8 polynomial 0x1D, preset 0xFF
// - Latest identity request sets response mode (code ignores requests in the streaming state)
`ifndef RTMCH_REGS_VH
`define RTMCH_REGS_VH
`define RTMCH_REG_STATUS 8'h00
`define RTMCH_REG_SERIAL 8'h04
`define RTMCH_REG_MEM_ADDR 8'h08
`define RTMCH_REG_MEM_DATA 8'h0C
`define RTMCH_SERIAL_RST 32'h00000000
`define RTMCH_CMD_READ_PAGE 4'hC
`define RTMCH_CMD_READ_BLOCK 4'hD
`define RTMCH_CMD_WRITE_PAGE 4'h8
`define RTMCH_CMD_WRITE_BLOCK 4'h9
`define RTMCH_CMD_SILENCE 4'h7
`define RTMCH_SELQ_PREFIX 5'h00
`define RTMCH_LEN_CMD 6'h14
`define RTMCH_LEN_SELQ 6'h2D
`define RTMCH_LEN_WDATA 6'h28
`define RTMCH_CRC_POLY 8'h1D
`define RTMCH_CRC_PRESET 8'hFF
`define RTMCH_MODE_STD 2'h0
`define RTMCH_MODE_ADV 2'h1
`define RTMCH_MODE_FADV 2'h2
`define RTMCH_SOF_LAST_STD 8'h00
`define RTMCH_SOF_LAST_ADV 8'h05
`define RTMCH_RATE_4K 2'h0
`define RTMCH_RATE_8K 2'h1
`define RTMCH_CODE_MANCH 1'h0
`define RTMCH_CFG_PAGE 6'h01
`define RTMCH_CFG_CODING 8
`define RTMCH_CFG_RATE_LO 9
`define RTMCH_CFG_RATE_HI 10
`define RTMCH_CFG_LEN_LO 11
`define RTMCH_CFG_LEN_HI 12
`define RTMCH_CFG_TTF_EN 13
`define RTMCH_CFG_AUTH 15
`define RTMCH_STREAM_PAGE 6'h04
`define RTMCH_CLK_MHZ 50
`define RTMCH_T_WRESP_US 200
`define RTMCH_T_PROG_US 5000
`define RTMCH_T_RESET_US 5000
`define RTMCH_STREAM_START_DELAY_US 10000
`define RTMCH_T_WRESP_CYC (`RTMCH_T_WRESP_US * `RTMCH_CLK_MHZ)
`define RTMCH_T_PROG_CYC (`RTMCH_T_PROG_US * `RTMCH_CLK_MHZ)
`define RTMCH_T_RESET_CYC (`RTMCH_T_RESET_US * `RTMCH_CLK_MHZ)
`define RTMCH_STREAM_START_DELAY_CYC (`RTMCH_STREAM_START_DELAY_US * `RTMCH_CLK_MHZ)
`endif

// >>> rtmch_assertions.sv
// Port checks for the tag command handler
`timescale 1ns/1ps
module rtmch_assertions (
  input wire i_ref_clk,
  input wire i_srst,
  input wire i_field_on,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire o_avs_waitrequest,
  input wire o_tx_valid,
  input wire o_tx_bit,
  input wire i_tx_ready,
  input wire o_tx_stream,
  input wire o_tx_code_sel,
  input wire [6:0] o_tag_state
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_srst);
  sequence req_new;
    $rose(i_avs_read) || $rose(i_avs_write);
  endsequence
  sequence sof_bit;
    o_tx_valid && o_tx_bit;
  endsequence
  // Released reset leaves the tag ready
  reset_ready_a: assert property ($fell(i_srst) |-> o_tag_state == 7'h01)
    else $error("tag not ready after reset");
  wait_state_a: assert property (req_new |-> o_avs_waitrequest)
    else $error("new request without wait state");
  read_answer_a: assert property ($rose(i_avs_read) |=> !o_avs_waitrequest)
    else $error("read not answered in second cycle");
  state_onehot_a: assert property ($onehot(o_tag_state))
    else $error("tag state not one-hot");
  tx_hold_a: assert property (
    o_tx_valid && !i_tx_ready && i_field_on |=>
    o_tx_valid && $stable(o_tx_bit))
    else $error("reply bit dropped or changed while stalled");
  reply_coding_a: assert property (
    o_tx_valid && !o_tx_stream |-> !o_tx_code_sel)
    else $error("reply not in Manchester coding");
  sof_first_a: assert property (
    $rose(o_tx_valid) && !o_tx_stream |-> sof_bit)
    else $error("reply does not open with start bit");
  quiet_hold_a: assert property (
    o_tag_state == 7'h10 && !o_tx_valid |=> !o_tx_valid)
    else $error("silenced tag transmits");
  stream_state_a: assert property (o_tx_stream |-> o_tag_state == 7'h40)
    else $error("stream outside streaming state");
endmodule

// >>> rtmch_reader.sv
// Reader model: sends CRC framed commands and consumes reply bits
`timescale 1ns/1ps
module rtmch_reader (
  input wire i_clk,
  input wire i_tx_valid,
  input wire i_tx_bit,
  output logic o_rx_valid,
  output logic o_rx_bit,
  output logic o_rx_eof,
  output logic o_tx_ready,
  output logic o_got,
  output logic o_got_bit
);
  // Receive side idles low until the first frame
  initial {o_rx_valid, o_rx_bit, o_rx_eof} = 3'h0;
  // Random stalls: the modulator is not always ready
  always @(posedge i_clk) begin
    o_got <= i_tx_valid && o_tx_ready;
    o_got_bit <= i_tx_bit;
    o_tx_ready <= ($urandom % 4) != 0;
  end
  task automatic frame(input logic [39:0] d, input int n, input bit bad);
    logic [7:0] c;
    c = 8'hFF;
    for (int i = n - 1; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h1D : 8'h00);
    for (int i = n + 7; i >= 0; i--) begin
      @(posedge i_clk);
      o_rx_valid <= 1'b1;
      o_rx_bit <= (i >= 8) ? d[i - 8] : c[i] ^ (bad && i == 0);
    end
    @(posedge i_clk);
    o_rx_valid <= 1'b0;
    o_rx_eof <= 1'b1;
    @(posedge i_clk);
    o_rx_eof <= 1'b0;
    o_rx_bit <= ~o_rx_bit;
  endtask
endmodule

// >>> rtmch_core_test.sv
// Bench for the tag command handler: bus, air frames and replies
`timescale 1ns/1ps
module rtmch_core_test;
  logic clk, srst, rd, wr, fon, idr, sel, aok;
  logic [3:0] be;
  logic [1:0] idm;
  logic [7:0] adr;
  logic [31:0] wd, q, wv;
  logic [31:0] pg [4:7];
  wire [31:0] rdat;
  wire [6:0] st;
  wire [1:0] rate;
  wire wt, txv, txb, strm, csel, rxv, rxb, eof, rdy, got, gotb;
  int n_mismatch, checks;
  logic exq [$];
  rtmch_core #(.P_WRESP_CYC(20), .P_PROG_CYC(40), .P_RESET_CYC(30),
    .P_TTF_CYC(50)) dut (.i_ref_clk(clk), .i_srst(srst),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wt), .i_field_on(fon), .i_rx_valid(rxv),
    .i_rx_bit(rxb), .i_rx_eof(eof), .i_id_req(idr), .i_id_mode(idm),
    .i_select_ok(sel), .i_auth_ok(aok), .o_tx_valid(txv), .o_tx_bit(txb),
    .i_tx_ready(rdy), .o_tx_stream(strm), .o_tx_code_sel(csel),
    .o_tx_rate(rate), .o_tag_state(st));
  rtmch_reader rdr (.i_clk(clk), .i_tx_valid(txv), .i_tx_bit(txb),
    .o_rx_valid(rxv), .o_rx_bit(rxb), .o_rx_eof(eof), .o_tx_ready(rdy),
    .o_got(got), .o_got_bit(gotb));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("n_mismatch=%0d checks=%0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Air order: low byte first, MSB first in each byte
  function automatic logic [31:0] air(input logic [31:0] w);
    return {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction
  task automatic expw(input logic [31:0] w);
    logic [31:0] a;
    a = air(w);
    for (int i = 31; i >= 0; i--)
      exq.push_back(a[i]);
  endtask
  task automatic ack;
    exq.push_back(1'b1);
    exq.push_back(1'b0);
    exq.push_back(1'b1);
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    do
      @(posedge clk);
    while (wt !== 1'b0);
    r = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  // Gap after each reply doubles as the write setup wait
  task automatic drain;
    int k;
    k = 0;
    while (exq.size() > 0 && k < 3000) begin
      @(posedge clk);
      k++;
    end
    repeat (60) @(posedge clk);
    chk(exq.size(), 0);
  endtask
  // Empty queue expects no bit at all
  always @(posedge clk) begin
    if (got === 1'b1)
      chk(gotb, exq.size() ? exq.pop_front() : 1'bX);
  end
  initial begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    end_of_test;
  end
  initial begin
    srst = 1'b1;
    {rd, wr, idr, sel, aok} = 5'h00;
    be = 4'hF;
    idm = 2'h0;
    fon = 1'b1;
    adr = 8'h00;
    wd = 32'h0;
    void'($urandom(97));
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    bus(0, 8'h00, 32'h0, q);
    chk(q[6:0], 7'h01);
    bus(0, 8'h40, 32'h0, q);
    chk(q, 32'h0);
    bus(1, 8'h08, 32'h1, q);
    bus(1, 8'h0C, 32'h8000, q);
    for (int p = 4; p < 8; p++) begin
      pg[p] = $urandom;
      // page 4 opens with a start byte
      if (p == 4) pg[p][7:0] = 8'hFF;
      bus(1, 8'h08, p, q);
      bus(1, 8'h0C, pg[p], q);
    end
    rdr.frame(32'hC05, 12, 0);
    drain;
    idr <= 1'b1;
    @(posedge clk);
    idr <= 1'b0;
    sel <= 1'b1;
    @(posedge clk);
    sel <= 1'b0;
    repeat (2) @(posedge clk);
    chk(st, 7'h04);
    aok <= 1'b1;
    @(posedge clk);
    aok <= 1'b0;
    repeat (2) @(posedge clk);
    chk(st, 7'h08);
    rdr.frame(32'hC05, 12, 1);
    drain;
    exq.push_back(1'b1);
    expw(pg[5]);
    rdr.frame(32'hC05, 12, 0);
    drain;
    exq.push_back(1'b1);
    expw(pg[6]);
    expw(pg[7]);
    rdr.frame(32'hD06, 12, 0);
    drain;
    wv = $urandom;
    ack;
    rdr.frame(32'h802, 12, 0);
    drain;
    ack;
    rdr.frame(air(wv), 32, 0);
    drain;
    bus(1, 8'h08, 32'h2, q);
    bus(0, 8'h0C, 32'h0, q);
    chk(q, wv);
    ack;
    rdr.frame(32'h906, 12, 0);
    drain;
    ack;
    rdr.frame(air(~wv), 32, 0);
    drain;
    ack;
    rdr.frame(air(wv), 32, 0);
    drain;
    bus(1, 8'h08, 32'h7, q);
    bus(0, 8'h0C, 32'h0, q);
    chk(q, wv);
    bus(1, 8'h08, 32'h6, q);
    bus(0, 8'h0C, 32'h0, q);
    chk(q, ~wv);
    ack;
    rdr.frame(32'h73F, 12, 0);
    drain;
    chk(st, 7'h10);
    rdr.frame(32'hC04, 12, 0);
    drain;
    fon <= 1'b0;
    repeat (20) @(posedge clk);
    chk(st, 7'h10);
    repeat (20) @(posedge clk);
    chk(st, 7'h01);
    wv = $urandom;
    bus(1, 8'h04, wv, q);
    be <= 4'h1;
    bus(1, 8'h04, 32'h0, q);
    be <= 4'hF;
    wv[7:0] = 8'h00;
    bus(1, 8'h08, 32'h1, q);
    bus(1, 8'h0C, 32'h2000, q);
    fon <= 1'b1;
    idm <= 2'h1;
    repeat (5) @(posedge clk);
    idr <= 1'b1;
    @(posedge clk);
    idr <= 1'b0;
    bus(0, 8'h00, 32'h0, q);
    chk(q[14:12], 3'h5);
    repeat (5) exq.push_back(1'b1);
    ack;
    rdr.frame(air(wv), 37, 0);
    drain;
    chk(st, 7'h10);
    fon <= 1'b0;
    repeat (40) @(posedge clk);
    bus(1, 8'h0C, 32'h3F00, q);
    repeat (3) expw(pg[4]);
    fon <= 1'b1;
    while (exq.size() > 40) @(posedge clk);
    chk({strm, csel, rate}, 4'hF);
    chk(st, 7'h40);
    fon <= 1'b0;
    repeat (40) @(posedge clk);
    exq.delete();
    drain;
    end_of_test;
  end
endmodule
bind rtmch_core rtmch_assertions chk_u (.i_ref_clk(i_ref_clk),
  .i_srst(i_srst), .i_field_on(i_field_on), .i_avs_read(i_avs_read),
  .i_avs_write(i_avs_write),
  .o_avs_waitrequest(o_avs_waitrequest), .o_tx_valid(o_tx_valid),
  .o_tx_bit(o_tx_bit), .i_tx_ready(i_tx_ready), .o_tx_stream(o_tx_stream),
  .o_tx_code_sel(o_tx_code_sel), .o_tag_state(o_tag_state));
